// ==== inc/sfc_regs.svh ====
// Constants for the SSP link flow-control block: timing, limits, codes and
// header field positions. Assumes a 125 MHz dword clock.
`ifndef SFC_REGS_SVH
`define SFC_REGS_SVH
`define SFC_CLK_NS   8
`define SFC_MS_NS    1000000
`define SFC_MS_CYC   (`SFC_MS_NS / `SFC_CLK_NS)
`define SFC_TW       17
`define SFC_CRED_MAX 8'hff
`define SFC_LEN_MIN  9'h007
`define SFC_LEN_MAX  9'h107
`define SFC_FIFO_D   8
`define SFC_FT_DATA  8'h01
`define SFC_FT_XFER  8'h05
`define SFC_FT_CMD   8'h06
`define SFC_FT_RESP  8'h07
`define SFC_FT_TASK  8'h16
`define SFC_HB_FT    95
`define SFC_HB_DST   87
`define SFC_HB_SRC   55
`define SFC_HB_TLR   12
`define SFC_HB_RDF   10
`define SFC_HB_RTX   9
`define SFC_HB_CDP   8
`define SFC_HB_FILL  1
`endif

// ==== inc/sfc_pkg.sv ====
// Types shared by the SSP flow-control block and its helpers.
// Assumes sfc_regs.svh is on the include path.
`include "sfc_regs.svh"
package sfc_pkg;
	typedef enum logic [1:0] {
		SFC_ST_IDLE  = 2'h0,
		SFC_ST_OPEN  = 2'h1,
		SFC_ST_DRAIN = 2'h3
	} sfc_state_t;
	typedef enum logic [1:0] {
		SFC_DN_NORMAL = 2'h0,
		SFC_DN_CREDIT = 2'h1,
		SFC_DN_ACKNAK = 2'h2
	} sfc_done_t;
	typedef struct packed {
		logic rrdy;
		logic ack;
		logic nak;
		logic cblk;
		logic done;
	} sfc_rxp_t;
	typedef struct packed {
		logic      rrdy;
		logic      ack;
		logic      nak;
		logic      cblk;
		logic      done;
		sfc_done_t kind;
		logic      close;
		logic      brk;
	} sfc_txp_t;
	typedef struct packed {
		logic        fin;
		logic        err;
		logic [8:0]  len;
		logic [15:0] tag;
		logic [95:0] hdr;
	} sfc_rxf_t;
	typedef struct packed {
		logic [7:0]  ftype;
		logic [23:0] dst;
		logic [23:0] src;
		logic [1:0]  tlr;
		logic        rdf;
		logic        rtx;
		logic        cdp;
		logic [1:0]  fill;
	} sfc_hdr_t;
	typedef struct packed {
		logic [7:0]  ftype;
		logic [15:0] tag;
	} sfc_rxd_t;
	typedef struct packed {
		logic       delivered;
		logic       naked;
		logic       failed;
		logic [7:0] fail_cnt;
	} sfc_rep_t;
	function automatic logic sfc_is_il(input logic [7:0] ft);
		return ft == `SFC_FT_CMD || ft == `SFC_FT_TASK ||
			ft == `SFC_FT_XFER || ft == `SFC_FT_RESP;
	endfunction
endpackage

// ==== core/sfc_fifo.sv ====
// Synchronous FIFO with a registered output stage.
// Assumes one clock; the output stage adds one word beyond DEPTH.
`timescale 1ns/10ps
module sfc_fifo #(
	parameter int W = 24,
	parameter int D = 8
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data,
	output logic [$clog2(D):0] free
);
	localparam int AW = $clog2(D);
	localparam int CW = AW + 1;
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
		logic          ov;
		logic [W-1:0]  od;
	} sfc_fifo_st_t;
	sfc_fifo_st_t s, n;
	logic [W-1:0] mem [D];
	logic push, load;

	always_comb begin
		n = s;
		in_ready = s.cnt != CW'(D);
		push = in_valid && in_ready;
		load = s.cnt != '0 && (!s.ov || out_ready);
		if (push) begin
			n.wp = s.wp + AW'(1);
		end
		if (load) begin
			n.rp = s.rp + AW'(1);
			n.od = mem[s.rp];
			n.ov = 1'b1;
		end else if (out_ready) begin
			n.ov = 1'b0;
		end
		n.cnt = s.cnt + CW'(push) - CW'(load);
		free = CW'(D) - s.cnt;
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[s.wp] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign out_valid = s.ov;
	assign out_data = s.od;
endmodule

// ==== core/sfc_hdr.sv ====
// Splits the first twelve bytes of an SSP frame header into fields.
// Byte 0 sits in the top eight bits of the input word.
`timescale 1ns/10ps
`include "sfc_regs.svh"
module sfc_hdr import sfc_pkg::*; (
	input  wire logic [95:0] hdr,
	output sfc_hdr_t         fld
);
	always_comb begin
		fld.ftype = hdr[`SFC_HB_FT -: 8];
		fld.dst   = hdr[`SFC_HB_DST -: 24];
		fld.src   = hdr[`SFC_HB_SRC -: 24];
		fld.tlr   = hdr[`SFC_HB_TLR -: 2];
		fld.rdf   = hdr[`SFC_HB_RDF];
		fld.rtx   = hdr[`SFC_HB_RTX];
		fld.cdp   = hdr[`SFC_HB_CDP];
		fld.fill  = hdr[`SFC_HB_FILL -: 2];
	end
endmodule

// ==== core/sfc_link.sv ====
// SSP link flow control: credit, frame interlock, DONE/CLOSE shutdown
// and the receive acknowledge path into an 8-word transport FIFO.
// Assumes primitive decode/encode and framing sit outside on the same clock.
`timescale 1ns/10ps
`include "sfc_regs.svh"
module sfc_link import sfc_pkg::*; #(
	parameter int unsigned MS_CYC = `SFC_MS_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        is_init,
	input  wire logic        conn_open,
	input  wire logic        conn_break,
	input  wire logic        cb_req,
	input  wire logic        tx_req,
	input  wire logic        tx_idle,
	input  wire logic [95:0] tx_hdr,
	input  wire logic [15:0] tx_tag,
	input  wire sfc_rxp_t    rxp,
	input  wire sfc_rxf_t    rxf,
	input  wire logic        tl_ready,
	output logic             tx_go,
	output sfc_txp_t         txp,
	output sfc_rep_t         rep,
	output logic [7:0]       tx_credit,
	output logic             conn_active,
	output logic             tl_valid,
	output sfc_rxd_t         tl_data
);
	localparam logic [`SFC_TW-1:0] TMAX = `SFC_TW'(MS_CYC - 1);

	typedef struct packed {
		sfc_state_t          state;
		logic                act;
		logic [7:0]          credit;
		logic [7:0]          granted;
		logic                cb_sent;
		logic                peer_cb;
		logic [7:0]          unacked;
		logic                il_out;
		logic [15:0]         tag;
		logic                done_sent;
		logic                done_rcvd;
		logic [`SFC_TW-1:0]  cto;
		logic [`SFC_TW-1:0]  ato;
		logic [`SFC_TW-1:0]  dto;
		logic                tx_go;
		sfc_txp_t            txp;
		sfc_rep_t            rep;
	} sfc_st_t;

	sfc_st_t  s, n;
	sfc_hdr_t tx_fld;
	sfc_hdr_t rx_fld;
	sfc_rxd_t push_d;
	logic     tx_il, go, ackd, grant, len_ok, push, fifo_rdy, dn;
	logic [$clog2(`SFC_FIFO_D):0] fifo_free;

	sfc_hdr u_tx_hdr (
		.hdr (tx_hdr),
		.fld (tx_fld)
	);

	sfc_hdr u_rx_hdr (
		.hdr (rxf.hdr),
		.fld (rx_fld)
	);

	// The FIFO holds only frames that are answered with ACK, so the
	// transport side never sees a frame the link later rejects.
	sfc_fifo #(
		.W ($bits(sfc_rxd_t)),
		.D (`SFC_FIFO_D)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (push),
		.in_ready  (fifo_rdy),
		.in_data   (push_d),
		.out_valid (tl_valid),
		.out_ready (tl_ready),
		.out_data  (tl_data),
		.free      (fifo_free)
	);

	always_comb begin
		n = s;
		n.tx_go = 1'b0;
		n.txp = '0;
		n.rep = '0;
		tx_il = sfc_is_il(tx_fld.ftype);
		go = 1'b0;
		ackd = 1'b0;
		grant = 1'b0;
		len_ok = 1'b0;
		push = 1'b0;
		dn = 1'b0;
		push_d.ftype = rx_fld.ftype;
		push_d.tag = rxf.tag;
		case (s.state)
		SFC_ST_IDLE: begin
			if (conn_open) begin
				n = '0;
				n.state = SFC_ST_OPEN;
				n.act = 1'b1;
				n.credit = '0;
			end
		end
		SFC_ST_OPEN, SFC_ST_DRAIN: begin
			// Transmit ordering. A one-cycle gap after each grant lets
			// the source replace its request before it is looked at again.
			if (s.state == SFC_ST_OPEN && !s.done_sent && !s.tx_go &&
				tx_req && s.credit != '0) begin
				if (s.unacked == '0) begin
					go = 1'b1;
				end else if (!tx_il && !s.il_out && s.tag == tx_tag) begin
					go = 1'b1;
				end
			end
			if (go) begin
				n.tx_go = 1'b1;
				n.credit = s.credit - 8'h01;
				n.tag = tx_tag;
				n.il_out = s.il_out || tx_il;
			end
			if (rxp.rrdy && n.credit != `SFC_CRED_MAX) begin
				n.credit = n.credit + 8'h01;
			end

			// Answers to our own frames.
			ackd = (rxp.ack || rxp.nak) && s.unacked != '0;
			n.rep.delivered = rxp.ack && ackd;
			n.rep.naked = rxp.nak && ackd;
			n.unacked = s.unacked + {7'h00, go} - {7'h00, ackd};
			if (n.unacked == '0) begin
				n.il_out = 1'b0;
			end

			// Receive side runs regardless of any pending interlock.
			len_ok = rxf.len >= `SFC_LEN_MIN &&
				rxf.len <= `SFC_LEN_MAX;
			if (rxf.fin && len_ok) begin
				if (s.granted != '0) begin
					n.granted = s.granted - 8'h01;
				end
				if (rxf.err || !fifo_rdy) begin
					n.txp.nak = 1'b1;
				end else begin
					n.txp.ack = 1'b1;
					push = 1'b1;
				end
			end

			// Credit grant. Space is judged against the FIFO so a granted
			// frame can always be stored; a full buffer or a requested or sent
			// CREDIT_BLOCKED are the initiator's only reasons to hold back.
			if (!s.cb_sent && !cb_req && s.granted != `SFC_CRED_MAX &&
				8'(fifo_free) > s.granted) begin
				grant = is_init || !tx_req;
			end
			if (grant) begin
				n.txp.rrdy = 1'b1;
				n.granted = n.granted + 8'h01;
			end
			if (cb_req && !s.cb_sent) begin
				n.txp.cblk = 1'b1;
				n.cb_sent = 1'b1;
			end
			if (rxp.cblk) begin
				n.peer_cb = 1'b1;
			end
			if (rxp.done) begin
				n.done_rcvd = 1'b1;
			end

			// Timers saturate at their limit until the cause goes away.
			if (s.state == SFC_ST_OPEN && s.credit == '0 && tx_req &&
				!rxp.rrdy) begin
				n.cto = (s.cto == TMAX) ? s.cto : s.cto + `SFC_TW'(1);
			end else begin
				n.cto = '0;
			end
			if (s.unacked != '0 && !ackd) begin
				n.ato = (s.ato == TMAX) ? s.ato : s.ato + `SFC_TW'(1);
			end else begin
				n.ato = '0;
			end

			if (s.state == SFC_ST_OPEN && !go && !s.tx_go) begin
				if (tx_idle && !tx_req && s.unacked == '0) begin
					dn = 1'b1;
					n.txp.kind = SFC_DN_NORMAL;
				end else if (s.unacked != '0 && s.ato == TMAX) begin
					dn = 1'b1;
					n.txp.kind = SFC_DN_ACKNAK;
				end else if (s.credit == '0 && tx_req &&
					(s.cto == TMAX || s.peer_cb)) begin
					dn = 1'b1;
					n.txp.kind = SFC_DN_CREDIT;
				end
			end
			if (dn) begin
				n.txp.done = 1'b1;
				n.done_sent = 1'b1;
				n.state = SFC_ST_DRAIN;
				n.dto = '0;
			end

			if (s.state == SFC_ST_DRAIN) begin
				n.dto = (s.dto == TMAX) ? s.dto : s.dto + `SFC_TW'(1);
				if (s.done_rcvd) begin
					n.txp.close = 1'b1;
					n.state = SFC_ST_IDLE;
					n.act = 1'b0;
				end else if (s.dto == TMAX) begin
					// Covers the ACK/NAK timeout too: BREAK 1 ms after DONE.
					n.txp.brk = 1'b1;
					n.state = SFC_ST_IDLE;
					n.act = 1'b0;
				end
			end

			// Any frame still unanswered when the link drops is lost.
			if (conn_break || n.txp.brk) begin
				n.rep.failed = 1'b1;
				n.rep.fail_cnt = n.unacked;
				n.state = SFC_ST_IDLE;
				n.act = 1'b0;
				n.txp.close = 1'b0;
			end
		end
		default: begin
			n = '0;
		end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign tx_go = s.tx_go;
	assign txp = s.txp;
	assign rep = s.rep;
	assign tx_credit = s.credit;
	assign conn_active = s.act;

	default clocking cb_clk @(posedge clk);
	endclocking
	default disable iff (rst);

	a_open_credit_zero: assert property (
		s.state == SFC_ST_IDLE && conn_open |=> tx_credit == 8'h00
	) else $error("credit not zero after connection open");

	a_go_takes_credit: assert property (
		!s.tx_go ##1 s.tx_go && !$past(rxp.rrdy)
		|-> tx_credit == $past(tx_credit) - 8'h01
	) else $error("frame sent without taking one credit");

	a_grant_cap: assert property (
		txp.rrdy |-> $past(s.granted) != `SFC_CRED_MAX
	) else $error("credit granted past the limit");

	a_no_rrdy_blocked: assert property (
		txp.cblk |-> ##1 (!txp.rrdy && s.cb_sent) [*8]
	) else $error("RRDY sent after CREDIT_BLOCKED");

	a_il_needs_idle: assert property (
		n.tx_go && tx_il |-> s.unacked == 8'h00
	) else $error("interlocked frame sent with frames open");

	a_il_holds_tx: assert property (
		s.il_out && s.unacked != 8'h00 |-> !go
	) else $error("frame sent behind an open interlocked frame");

	a_ni_same_tag: assert property (
		n.tx_go && s.unacked != 8'h00 |-> !tx_il && !s.il_out &&
		s.tag == tx_tag
	) else $error("data frame sent past another tag");

	a_no_frame_done: assert property (
		txp.done |-> (!tx_go) [*8]
	) else $error("frame sent after DONE");

	a_close_on_done: assert property (
		s.state == SFC_ST_DRAIN && s.done_rcvd && !conn_break
		|=> txp.close && !conn_active
	) else $error("no CLOSE after DONE exchange");

	a_rx_answer: assert property (
		s.act && rxf.fin && len_ok |=> txp.ack != txp.nak
	) else $error("kept frame not answered");

	a_rx_discard: assert property (
		rxf.fin && !len_ok |=> !txp.ack && !txp.nak
	) else $error("short or long frame answered");

	a_fwd_acked: assert property (
		push |=> txp.ack ##1 tl_valid
	) else $error("forwarded frame not ACKed");

	a_break_report: assert property (
		s.act && conn_break |=> rep.failed && !conn_active
	) else $error("break did not report failed frames");
endmodule

// ==== testbench/sfc_peer.sv ====
// Model of the far phy: grants credit on request, acknowledges frames
// and returns DONE. Assumes the bench drives grant and ack_en.
`timescale 1ns/10ps
module sfc_peer import sfc_pkg::*; (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic tx_go,
	input  wire sfc_txp_t txp,
	input  wire logic grant,
	input  wire logic ack_en,
	output sfc_rxp_t  rxp
);
	logic [7:0] pend;
	logic [1:0] dly;
	logic       ack_now;
	// Acks come one every four cycles, so several frames can stay open.
	assign ack_now = ack_en && pend != 8'h00 && dly == 2'h0;
	always @(posedge clk) begin
		rxp <= '0;
		if (rst) begin
			pend <= 8'h00;
			dly <= 2'h0;
		end else begin
			// The bench never asks for more than a few grants.
			rxp.rrdy <= grant;
			rxp.done <= txp.done;
			rxp.ack <= ack_now;
			dly <= dly + 2'h1;
			pend <= pend + 8'(tx_go) - 8'(ack_now);
		end
	end
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for sfc_link: credit, interlock, receive, shutdown.
// Assumes sfc_peer plays the far phy and MS_CYC is shortened to 40.
// The short timer still leaves room for the peer's slow acknowledges.
`timescale 1ns/10ps
`include "sfc_regs.svh"
module tb_top import sfc_pkg::*; ;
	logic        clk = 1'h0, rst = 1'h1, is_init = 1'h1, conn_open = 1'h0;
	logic        conn_break = 1'h0, cb_req = 1'h0, tx_req = 1'h0;
	logic        tx_idle = 1'h0, tl_ready = 1'h1, grant = 1'h0;
	logic        ack_en = 1'h0;
	logic [95:0] tx_hdr = '0;
	logic [15:0] tx_tag = '0;
	sfc_rxf_t    rxf = '0;
	sfc_rxp_t    rxp;
	logic        tx_go, conn_active, tl_valid;
	sfc_txp_t    txp;
	sfc_rep_t    rep;
	logic [7:0]  tx_credit, last_fail;
	sfc_rxd_t    tl_data, last_tl;
	sfc_done_t   last_kind;
	int          fails = 0, checks_done = 0, cyc = 0;
	int          n_go, n_rr, n_cb, n_ack, n_nak, n_tl, n_done, n_cl, n_dlv;

	always #4 clk = ~clk;

	sfc_link #(.MS_CYC(40)) sfc_link_inst (
		.clk(clk), .rst(rst), .is_init(is_init), .conn_open(conn_open),
		.conn_break(conn_break), .cb_req(cb_req), .tx_req(tx_req),
		.tx_idle(tx_idle), .tx_hdr(tx_hdr), .tx_tag(tx_tag), .rxp(rxp),
		.rxf(rxf), .tl_ready(tl_ready), .tx_go(tx_go), .txp(txp),
		.rep(rep), .tx_credit(tx_credit), .conn_active(conn_active),
		.tl_valid(tl_valid), .tl_data(tl_data)
	);
	sfc_peer sfc_peer_inst (
		.clk(clk), .rst(rst), .tx_go(tx_go), .txp(txp), .grant(grant),
		.ack_en(ack_en), .rxp(rxp)
	);

	// Outputs are sampled at the edge, before the flops move.
	always @(posedge clk) begin
		cyc++;
		if (tx_go) n_go++;
		if (txp.rrdy) n_rr++;
		if (txp.cblk) n_cb++;
		if (txp.ack) n_ack++;
		if (txp.nak) n_nak++;
		if (txp.close) n_cl++;
		if (rep.delivered) n_dlv++;
		if (rep.failed) last_fail = rep.fail_cnt;
		if (tl_valid && tl_ready) begin
			n_tl++;
			last_tl = tl_data;
		end
		if (txp.done) begin
			n_done++;
			last_kind = txp.kind;
		end
		if (cyc == 5000) begin
			fails++;
			print_verdict();
		end
	end

	task automatic step(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
		end
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic restart(input logic init);
		rst = 1'h1;
		is_init = init;
		step(8);
		rst = 1'h0;
		{n_go, n_rr, n_cb, n_ack, n_nak, n_tl, n_done, n_cl, n_dlv} = '0;
		step(1);
		chk({tx_credit, conn_active}, 0);
		conn_open = 1'h1;
		step(1);
		conn_open = 1'h0;
		step(1);
	endtask
	task automatic send(input logic [7:0] ft, input logic [15:0] tag);
		int i;
		tx_hdr = {ft, 88'h0};
		tx_tag = tag;
		tx_req = 1'h1;
		for (i = 0; i < 40 && tx_go !== 1'h1; i++) step(1);
		tx_req = 1'h0;
		chk(tx_go, 1);
	endtask
	task automatic hold(input logic [7:0] ft, input logic [15:0] tag);
		tx_hdr = {ft, 88'h0};
		tx_tag = tag;
		tx_req = 1'h1;
		step(6);
		tx_req = 1'h0;
		step(1);
	endtask
	task automatic rx(input logic [8:0] len, input logic err);
		rxf.len = len;
		rxf.err = err;
		rxf.fin = 1'h1;
		step(1);
		rxf.fin = 1'h0;
		step(3);
	endtask

	task automatic s_init();
		int i;
		for (i = 0; i < 2; i++) begin
			tx_hdr = {`SFC_FT_DATA, 88'h0};
			tx_req = 1'h1;
			restart(i[0]);
			step(5);
			chk(n_rr != 0, i);
			step(50);
			tx_req = 1'h0;
			chk(n_done, 1);
			chk(last_kind, SFC_DN_CREDIT);
			chk(n_cl, 1);
		end
	endtask
	task automatic s_credit();
		restart(1'h1);
		cb_req = 1'h1;
		step(20);
		chk(n_cb, 1);
		chk(n_rr < 4, 1);
		cb_req = 1'h0;
		grant = 1'h1;
		step(3);
		grant = 1'h0;
		step(2);
		chk(tx_credit, 3);
		tx_hdr = {`SFC_FT_DATA, 88'h0};
		tx_tag = 16'h0001;
		tx_req = 1'h1;
		step(10);
		tx_req = 1'h0;
		chk(n_go, 3);
		chk(tx_credit, 0);
		conn_break = 1'h1;
		step(1);
		conn_break = 1'h0;
		step(2);
		chk(last_fail, 3);
		chk(conn_active, 0);
	endtask
	task automatic s_lock();
		restart(1'h1);
		grant = 1'h1;
		step(4);
		grant = 1'h0;
		send(`SFC_FT_DATA, 16'h0001);
		hold(`SFC_FT_CMD, 16'h0001);
		chk(n_go, 1);
		hold(`SFC_FT_DATA, 16'h0002);
		chk(n_go, 1);
		send(`SFC_FT_DATA, 16'h0001);
		ack_en = 1'h1;
		step(12);
		ack_en = 1'h0;
		chk(n_dlv, 2);
		send(`SFC_FT_CMD, 16'h0002);
		hold(`SFC_FT_DATA, 16'h0002);
		chk(n_go, 3);
		chk(tx_credit, 1);
		rxf.hdr = {`SFC_FT_XFER, 88'h0};
		rx(9'h008, 1'h0);
		chk(n_ack, 1);
		step(50);
		chk(last_kind, SFC_DN_ACKNAK);
		chk(n_cl, 1);
	endtask
	task automatic s_rx();
		restart(1'h1);
		rxf.hdr = {`SFC_FT_CMD, 88'h0};
		rxf.tag = 16'h00a5;
		rx(9'h006, 1'h0);
		rx(9'h007, 1'h0);
		rx(9'h107, 1'h1);
		rx(9'h108, 1'h0);
		rx(9'h107, 1'h0);
		chk(n_ack, 2);
		chk(n_nak, 1);
		chk(n_tl, 2);
		chk(last_tl, {8'h06, 16'h00a5});
	endtask
	task automatic s_done();
		restart(1'h1);
		tx_idle = 1'h1;
		step(6);
		tx_idle = 1'h0;
		chk(n_done, 1);
		chk(last_kind, SFC_DN_NORMAL);
		chk(n_cl, 1);
	endtask

	task automatic print_verdict();
		$display("checks_done=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		s_init();
		s_credit();
		s_lock();
		s_rx();
		s_done();
		print_verdict();
	end
endmodule
